//--- src/slc_link_ctrl.sv
/*
 file: register bank, sync source mux, test pattern generator and link status for one serial lane
 assumes: one frame clock; register port is a simple synchronous write/read strobe pair from the spi slave;
 sync pins already combined to one active-low level; the serializer drains lane_word_out with valid/ready
*/
// What this block does
// - bit 7 picks pins or software sync
// - software sync bit low requests sync
// - software sync ignored while pins selected
// - pattern selector bits 3:0, zero is normal
// - codes 1 and 2 send prbs7, prbs15
// - code 5 repeats ila, code 6 ramp
// - code 7 k28.5, code 8 d21.5
// - codes 9 and 10 hold lane low, high
// - ramp step 16 bits at 0x62 and 0x63
// - status bit 6 set once data flows
// - disabled link sends alternating 0101 stream
// - sync request needs four frame clocks
`timescale 1ns/1ps
`include "slc_params.svh"
module slc_link_ctrl #(
  parameter int SAMPLE_W = 16,
  parameter logic [7:0] ILA_FRAMES = `SLC_ILA_FRAMES
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic link_enable_in,
  input wire logic pin_sync_request_n_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic lane_ready_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic [10:0] lane_word_out,
  output logic lane_valid_out,
  output logic link_up_out
);

  ////////////////////////////////////////////////////////////////////////////
  slc_pkg::slc_ctrl2_t ctrl2_ff;
  logic [15:0] ramp_step_value_ff;
  slc_pkg::slc_state_t state_ff;
  slc_pkg::slc_state_t nxt_state;
  logic [2:0] sync_cnt_ff;
  logic [7:0] ila_cnt_ff;
  logic [22:0] prbs_ff;
  logic [SAMPLE_W-1:0] ramp_ff;
  logic link_up_ff;
  logic int_sync_n;
  logic sync_held;
  slc_pkg::slc_word_t gen_word;
  logic gen_ready;
  slc_pkg::slc_word_t buf_ff [2];
  logic [1:0] buf_cnt_ff;
  logic buf_rd_ff;
  logic buf_wr_ff;
  logic push;
  logic pop;

  function automatic logic [9:0] fold_sample(input logic [SAMPLE_W-1:0] s);
    fold_sample = s[9:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes; software keeps reserved bits zero and step non-zero
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl2_ff <= `SLC_RST_CTRL2;
      ramp_step_value_ff <= {`SLC_RST_STEP_HI, `SLC_RST_STEP_LO};
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `SLC_ADDR_CTRL2)
        ctrl2_ff <= reg_wdata_in;
      if (reg_addr_in == `SLC_ADDR_STEP_LO)
        ramp_step_value_ff[7:0] <= reg_wdata_in;
      if (reg_addr_in == `SLC_ADDR_STEP_HI)
        ramp_step_value_ff[15:8] <= reg_wdata_in;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in;
      unique case (reg_addr_in)
        `SLC_ADDR_CTRL2: reg_rdata_out <= ctrl2_ff;
        `SLC_ADDR_STEP_LO: reg_rdata_out <= ramp_step_value_ff[7:0];
        `SLC_ADDR_STEP_HI: reg_rdata_out <= ramp_step_value_ff[15:8];
        `SLC_ADDR_STATUS: reg_rdata_out <= 8'(link_up_ff) << `SLC_BIT_LINK_UP;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync source select
  // soft bit ignored on pin source
  assign int_sync_n = ctrl2_ff.sync_sel ? ctrl2_ff.soft_sync_request_n : pin_sync_request_n_in;

  // count request length, short pulses ignored
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      sync_cnt_ff <= 3'h0;
    else if (int_sync_n)
      sync_cnt_ff <= 3'h0;
    else if (sync_cnt_ff != `SLC_SYNC_MIN_FRAMES)
      sync_cnt_ff <= sync_cnt_ff + 3'h1;
  end
  assign sync_held = (sync_cnt_ff == `SLC_SYNC_MIN_FRAMES);

  // link state: ila count only advances on words actually taken
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      slc_pkg::SLC_ST_IDLE: if (link_enable_in) nxt_state = slc_pkg::SLC_ST_SYNC;
      // leaves only through a full request released or link disable, below
      slc_pkg::SLC_ST_SYNC: ;
      slc_pkg::SLC_ST_ILA: if (push && ila_cnt_ff == ILA_FRAMES - 8'h01) nxt_state = slc_pkg::SLC_ST_DATA;
      slc_pkg::SLC_ST_DATA: ;
    endcase
    if (!link_enable_in)
      nxt_state = slc_pkg::SLC_ST_IDLE;
    else if (sync_held && state_ff != slc_pkg::SLC_ST_IDLE)
      nxt_state = int_sync_n ? slc_pkg::SLC_ST_ILA : slc_pkg::SLC_ST_SYNC;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      state_ff <= slc_pkg::SLC_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      ila_cnt_ff <= 8'h00;
    else if (state_ff != slc_pkg::SLC_ST_ILA || sync_held)
      ila_cnt_ff <= 8'h00;
    else if (push)
      ila_cnt_ff <= ila_cnt_ff + 8'h01;
  end

  // link up only with data flowing
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      link_up_ff <= 1'b0;
    else
      link_up_ff <= (nxt_state == slc_pkg::SLC_ST_DATA);
  end
  assign link_up_out = link_up_ff;

  ////////////////////////////////////////////////////////////////////////////
  // generators advance only when a word enters the buffer
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      prbs_ff <= 23'h7FFFFF;
    else if (push)
    begin
      unique case (ctrl2_ff.link_test_pattern_sel)
        slc_pkg::SLC_TP_PRBS7: prbs_ff <= {prbs_ff[21:0], prbs_ff[6] ^ prbs_ff[5]};
        slc_pkg::SLC_TP_PRBS15: prbs_ff <= {prbs_ff[21:0], prbs_ff[14] ^ prbs_ff[13]};
        slc_pkg::SLC_TP_PRBS23: prbs_ff <= {prbs_ff[21:0], prbs_ff[22] ^ prbs_ff[17]};
        default: prbs_ff <= prbs_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      ramp_ff <= '0;
    else if (push && ctrl2_ff.link_test_pattern_sel == slc_pkg::SLC_TP_RAMP)
      ramp_ff <= ramp_ff + SAMPLE_W'(ramp_step_value_ff);
  end

  always_comb
  begin
    gen_word = '{symbol: 10'h000, is_ctrl: 1'b0};
    if (state_ff == slc_pkg::SLC_ST_IDLE)
      gen_word.symbol = `SLC_ALT_PATTERN;
    else
    begin
      unique case (ctrl2_ff.link_test_pattern_sel)
        slc_pkg::SLC_TP_PRBS7, slc_pkg::SLC_TP_PRBS15, slc_pkg::SLC_TP_PRBS23: gen_word.symbol = prbs_ff[9:0];
        slc_pkg::SLC_TP_ILA: gen_word = '{symbol: `SLC_K285_RD_NEG, is_ctrl: 1'b1};
        slc_pkg::SLC_TP_RAMP: gen_word.symbol = fold_sample(ramp_ff);
        slc_pkg::SLC_TP_K285: gen_word = '{symbol: `SLC_K285_RD_NEG, is_ctrl: 1'b1};
        slc_pkg::SLC_TP_D215: gen_word.symbol = `SLC_D215;
        slc_pkg::SLC_TP_LOW: gen_word.symbol = 10'h000;
        slc_pkg::SLC_TP_HIGH: gen_word.symbol = 10'h3FF;
        default:
        begin
          if (state_ff == slc_pkg::SLC_ST_DATA)
            gen_word.symbol = fold_sample(sample_in);
          else
            gen_word = '{symbol: `SLC_K285_RD_NEG, is_ctrl: 1'b1};
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer: serializer stall loses no word
  assign gen_ready = (buf_cnt_ff != 2'h2);
  assign push = gen_ready;
  assign pop = lane_valid_out && lane_ready_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      buf_cnt_ff <= 2'h0;
      buf_rd_ff <= 1'b0;
      buf_wr_ff <= 1'b0;
    end
    else
    begin
      buf_cnt_ff <= buf_cnt_ff + 2'(push) - 2'(pop);
      if (push)
        buf_wr_ff <= ~buf_wr_ff;
      if (pop)
        buf_rd_ff <= ~buf_rd_ff;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
      buf_ff[buf_wr_ff] <= gen_word;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      lane_valid_out <= 1'b0;
      lane_word_out <= 11'h000;
    end
    else
    begin
      lane_valid_out <= (buf_cnt_ff + 2'(push) - 2'(pop)) != 2'h0;
      if (!lane_valid_out || pop)
        lane_word_out <= (buf_cnt_ff - 2'(pop)) != 2'h0 ? buf_ff[buf_rd_ff ^ pop] : gen_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short request never restarts sync
  a_sync_short_ignored: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    state_ff == slc_pkg::SLC_ST_DATA && link_enable_in && !sync_held |=> state_ff == slc_pkg::SLC_ST_DATA)
    else $error("link left data without full sync request");
  a_pin_source_used: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !ctrl2_ff.sync_sel && !pin_sync_request_n_in [*4] ##1 link_enable_in |-> sync_held)
    else $error("pin request not counted");
  a_link_up_data: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    $rose(link_up_ff) |-> $past(state_ff) == slc_pkg::SLC_ST_ILA && $past(ila_cnt_ff) == ILA_FRAMES - 8'h01)
    else $error("link up without complete alignment sequence");
  a_disable_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    !link_enable_in |=> state_ff == slc_pkg::SLC_ST_IDLE && !link_up_ff)
    else $error("disabled link not idle");
  a_step_write: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    reg_wr_in && reg_addr_in == `SLC_ADDR_STEP_HI |=> ramp_step_value_ff[15:8] == $past(reg_wdata_in))
    else $error("step high byte not stored");
  a_buffer_bound: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
    buf_cnt_ff <= 2'h2)
    else $error("buffer overflow");
  c_link_up: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) $rose(link_up_ff));
  c_stall: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) buf_cnt_ff == 2'h2);
  c_resync: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) link_up_ff ##1 sync_held);

endmodule // slc_link_ctrl

//--- src/slc_params.svh
/*
 file: register offsets, field positions, reset values and codes for the serial link control block
 assumes: included by the design file and the bench; no other definitions named SLC_
*/
`ifndef SLC_PARAMS_SVH
`define SLC_PARAMS_SVH
`define SLC_ADDR_CTRL2 8'h61
`define SLC_ADDR_STEP_LO 8'h62
`define SLC_ADDR_STEP_HI 8'h63
`define SLC_ADDR_STATUS 8'h6C
`define SLC_RST_CTRL2 8'h00
`define SLC_RST_STEP_LO 8'h01
`define SLC_RST_STEP_HI 8'h00
`define SLC_BIT_SYNC_SEL 7
`define SLC_BIT_SOFT_SYNC 6
`define SLC_BIT_LINK_UP 6
`define SLC_SYNC_MIN_FRAMES 3'h4
`define SLC_ALT_PATTERN 10'h155
`define SLC_K285_RD_NEG 10'h0FA
`define SLC_D215 10'h2AA
`define SLC_ILA_FRAMES 8'h04
`endif

//--- src/slc_pkg.sv
/*
 file: types for the serial link control block
 assumes: slc_params.svh sits beside it
*/
package slc_pkg;
  typedef enum logic [3:0] {
    SLC_TP_NORMAL = 4'h0,
    SLC_TP_PRBS7 = 4'h1,
    SLC_TP_PRBS15 = 4'h2,
    SLC_TP_PRBS23 = 4'h3,
    SLC_TP_ILA = 4'h5,
    SLC_TP_RAMP = 4'h6,
    SLC_TP_K285 = 4'h7,
    SLC_TP_D215 = 4'h8,
    SLC_TP_LOW = 4'h9,
    SLC_TP_HIGH = 4'hA
  } slc_pattern_t;

  typedef enum logic [1:0] {
    SLC_ST_IDLE = 2'b00,
    SLC_ST_SYNC = 2'b01,
    SLC_ST_ILA = 2'b11,
    SLC_ST_DATA = 2'b10
  } slc_state_t;

  typedef struct packed {
    logic sync_sel;
    logic soft_sync_request_n;
    logic [1:0] rsvd;
    logic [3:0] link_test_pattern_sel;
  } slc_ctrl2_t;

  typedef struct packed {
    logic [9:0] symbol;
    logic is_ctrl;
  } slc_word_t;
endpackage

//--- verification/slc_link_ctrl_tb.sv
/*
 bench for slc_link_ctrl: registers, sync source, sync length, lane patterns
 assumes: slc_rx_model stands at the lane and pin side
*/
`timescale 1ns/1ps
`include "slc_params.svh"
module slc_link_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [15:0] sample = 16'h02A5;
  logic start = 1'b0;
  logic [3:0] hold = 4'h0;
  logic stall = 1'b0;
  logic sync_n, ready, rvalid, valid, link_up;
  logic [7:0] rdata;
  logic [10:0] word;
  logic [9:0] sa, sb;
  int failures = 0;
  int checks = 0;
  slc_link_ctrl u_dut (.ref_clk_in(clk), .rst_b_in(rst_b), .link_enable_in(en),
    .pin_sync_request_n_in(sync_n), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .sample_in(sample), .lane_ready_in(ready), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .lane_word_out(word), .lane_valid_out(valid), .link_up_out(link_up));
  slc_rx_model u_rx (.ref_clk_in(clk), .start_in(start), .hold_in(hold), .stall_in(stall),
    .sync_request_n_out(sync_n), .lane_ready_out(ready));
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // answer lands one edge after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp({1'b0, rvalid, rdata}, {2'b01, exp});
  endtask
  task automatic pulse(input logic [3:0] h);
    @(posedge clk);
    start <= 1'b1;
    hold <= h;
    @(posedge clk);
    start <= 1'b0;
  endtask
  // sampled at the falling edge, clear of the launch edge
  task automatic get_sym(output logic [9:0] s);
    int n;
    n = 0;
    @(negedge clk);
    while (!(valid === 1'b1 && ready === 1'b1) && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    s = word[10:1];
    @(posedge clk);
  endtask
  // control two written with link off
  task automatic bring_up(input logic [7:0] ctrl);
    int n;
    @(posedge clk);
    en <= 1'b0;
    wr_reg(`SLC_ADDR_CTRL2, ctrl);
    @(posedge clk);
    en <= 1'b1;
    pulse(4'h4);
    n = 0;
    while (link_up !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    repeat (3) get_sym(sa);
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd_reg(`SLC_ADDR_CTRL2, `SLC_RST_CTRL2);
    rd_reg(`SLC_ADDR_STEP_LO, `SLC_RST_STEP_LO);
    rd_reg(`SLC_ADDR_STEP_HI, `SLC_RST_STEP_HI);
    rd_reg(`SLC_ADDR_STATUS, 8'h00);
    wr_reg(8'h70, 8'hFF);
    rd_reg(8'h70, 8'h00);
    wr_reg(`SLC_ADDR_CTRL2, 8'hC5);
    rd_reg(`SLC_ADDR_CTRL2, 8'hC5);
    $display("test regs done");
  endtask
  task automatic t_idle;
    stall <= 1'b1;
    repeat (3)
    begin
      get_sym(sa);
      cmp(sa, 10'h155);
    end
    stall <= 1'b0;
    $display("test idle done");
  endtask
  task automatic t_sync;
    bring_up(8'h00);
    cmp({9'h000, link_up}, 10'h001);
    rd_reg(`SLC_ADDR_STATUS, 8'h40);
    get_sym(sa);
    cmp(sa, 10'h2A5);
    wr_reg(8'h00, 8'h00);
    pulse(4'h3);
    repeat (20) @(negedge clk);
    cmp({9'h000, link_up}, 10'h001);
    pulse(4'h4);
    repeat (6) @(negedge clk);
    cmp({9'h000, link_up}, 10'h000);
    @(posedge clk);
    en <= 1'b0;
    repeat (5) @(negedge clk);
    cmp({9'h000, link_up}, 10'h000);
    $display("test sync done");
  endtask
  task automatic t_mux;
    bring_up(8'hC0);
    cmp({9'h000, link_up}, 10'h000);
    bring_up(8'h80);
    cmp({9'h000, link_up}, 10'h000);
    $display("test mux done");
  endtask
  task automatic t_patterns;
    logic [3:0] code [6] = '{4'h0, 4'h5, 4'h8, 4'h9, 4'hA, 4'h7};
    logic [9:0] exp [6] = '{10'h2A5, 10'h0FA, 10'h2AA, 10'h000, 10'h3FF, 10'h0FA};
    logic [3:0] other [5] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7};
    for (int i = 0; i < 6; i++)
    begin
      bring_up({4'h0, code[i]});
      get_sym(sa);
      cmp(sa, exp[i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      bring_up({4'h0, other[i]});
      get_sym(sa);
      get_sym(sb);
      if (other[i] == 4'h7)
        cmp({9'h000, sa == `SLC_K285_RD_NEG || sa == ~`SLC_K285_RD_NEG}, 10'h001);
      else
        cmp({9'h000, sa !== sb}, 10'h001);
    end
    $display("test patterns done");
  endtask
  task automatic t_ramp;
    // steps non-zero, written with link off
    logic [15:0] step [2] = '{16'h0003, 16'h0102};
    stall <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      en <= 1'b0;
      wr_reg(`SLC_ADDR_STEP_LO, step[i][7:0]);
      wr_reg(`SLC_ADDR_STEP_HI, step[i][15:8]);
      bring_up(8'h06);
      get_sym(sa);
      get_sym(sb);
      cmp(sb - sa, step[i][9:0]);
    end
    stall <= 1'b0;
    $display("test ramp done");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    failures++;
    test_done;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_idle;
    t_sync;
    t_mux;
    t_patterns;
    t_ramp;
    test_done;
  end
endmodule // slc_link_ctrl_tb

//--- verification/slc_rx_model.sv
/*
 receiver model: drives the active-low sync request pins and the lane ready level
 assumes: the bench pulses start_in for one cycle and gives the hold length with it
*/
`timescale 1ns/1ps
module slc_rx_model (
  input wire logic ref_clk_in,
  input wire logic start_in,
  input wire logic [3:0] hold_in,
  input wire logic stall_in,
  output logic sync_request_n_out,
  output logic lane_ready_out
);
  logic [3:0] hold_ff = 4'h0;
  logic [1:0] slow_ff = 2'h0;
  ////////////////////////////////////////////////////////////
  // request held hold_in frames
  always_ff @(posedge ref_clk_in)
  begin
    if (start_in)
      hold_ff <= hold_in;
    else if (hold_ff != 4'h0)
      hold_ff <= hold_ff - 4'h1;
  end
  assign sync_request_n_out = (hold_ff == 4'h0);
  // a stalling receiver takes one word in four, so the buffer must hold
  always_ff @(posedge ref_clk_in)
  begin
    slow_ff <= slow_ff + 2'h1;
  end
  assign lane_ready_out = !stall_in || (slow_ff == 2'h3);
endmodule // slc_rx_model
